// [hdl/fwps_top.sv]
// Write-protection, status and instruction gating of a serial NOR flash.
`timescale 1ns/1ps
`include "fwps_regs.svh"
module fwps_top (
  // Clock and power-on reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Serial link pins
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              si,
  input  wire logic              wp_n,
  output logic                   so,
  output logic                   so_oe,
  // Array engine
  output logic                   array_go,
  output fwps_pkg::fwps_op_e     array_op,
  output logic [23:0]            array_addr,
  output logic                   busy
);

  // Pin synchronisation; chip select is inverted so that reset means idle.
  logic [3:0] pin_s;
  fwps_sync #(.WIDTH(4)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     ({~cs_n, sclk, si, wp_n}),
    .dout    (pin_s)
  );

  wire sel_s  = pin_s[3];
  wire sclk_s = pin_s[2];
  wire si_s   = pin_s[1];
  wire wp_n_s = pin_s[0];

  logic                   sclk_d_r;
  logic                   sel_d_r;
  logic [2:0]             bit_cnt_r;
  logic [2:0]             byte_cnt_r;
  logic [7:0]             in_sh_r;
  logic [7:0]             opcode_r;
  logic [23:0]            buf_r;
  logic                   rd_r;
  logic [7:0]             out_sh_r;
  logic                   so_r;
  logic [1:0]             rd_sel_r;

  // Status and protection state.
  logic                   wel_r;
  logic [2:0]             bp_r;
  logic                   tb_r;
  logic                   sec_r;
  logic                   srp_r;
  logic                   srl_r;
  logic                   qe_r;
  logic                   cmp_r;
  logic                   wps_r;
  logic [`FWPS_LOCKS-1:0] lock_r;

  // Sequencing.
  fwps_pkg::fwps_state_e  st_r;
  fwps_pkg::fwps_state_e  st_nxt;
  logic [11:0]            puw_cnt_r;
  logic                   puw_done_r;
  logic [11:0]            run_cnt_r;
  fwps_pkg::fwps_op_e     op_r;
  logic                   go_r;
  logic [23:0]            addr_r;

  // Serial clock edges seen only while selected.
  wire sclk_rise = sel_s & sclk_s & ~sclk_d_r;
  wire sclk_fall = sel_s & ~sclk_s & sclk_d_r;
  wire frame_end = ~sel_s & sel_d_r;
  wire byte_done = sclk_rise & (bit_cnt_r == `FWPS_BIT_LAST);
  wire [7:0] new_byte = {in_sh_r[6:0], si_s};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
      sel_d_r  <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      sel_d_r  <= sel_s;
    end
  end

  // Byte assembly; counters restart whenever the chip is deselected.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !sel_s) begin
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 3'h0;
      in_sh_r    <= 8'h00;
    end else if (sclk_rise) begin
      in_sh_r   <= new_byte;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == `FWPS_BIT_LAST && byte_cnt_r != `FWPS_NB_MAX) begin
        byte_cnt_r <= byte_cnt_r + 3'h1;
      end
    end
  end

  // Opcode and up to three following bytes.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      opcode_r <= 8'h00;
      buf_r    <= 24'h000000;
    end else if (byte_done) begin
      if (byte_cnt_r == 3'h0) begin
        opcode_r <= new_byte;
      end else if (byte_cnt_r != `FWPS_NB_MAX - 3'h1 + 3'h1) begin
        buf_r <= {buf_r[15:0], new_byte};
      end
    end
  end

  // Status bytes as seen by software.
  wire       busy_bit = (st_r == fwps_pkg::FWPS_ST_BUSY);
  wire       sus_bit  = (st_r == fwps_pkg::FWPS_ST_SUSP);
  wire [7:0] sr1 = {srp_r, sec_r, tb_r, bp_r, wel_r, busy_bit};
  wire [7:0] sr2 = {sus_bit, cmp_r, 4'h0, qe_r, srl_r};
  wire [7:0] sr3 = {5'h00, wps_r, 2'h0};

  // A status read is honoured unless powered down.
  wire is_rd1   = (new_byte == `FWPS_OP_RDSR1);
  wire is_rd2   = (new_byte == `FWPS_OP_RDSR2);
  wire is_rd3   = (new_byte == `FWPS_OP_RDSR3);
  wire rd_start = byte_done & (byte_cnt_r == 3'h0) & (is_rd1 | is_rd2 | is_rd3)
                  & (st_r != fwps_pkg::FWPS_ST_DOWN);
  wire [1:0] rd_sel = is_rd1 ? 2'h1 : (is_rd2 ? 2'h2 : 2'h3);
  wire [7:0] rd_byte = (rd_sel_r == 2'h1) ? sr1 : ((rd_sel_r == 2'h2) ? sr2 : sr3);
  wire [7:0] first_byte = is_rd1 ? sr1 : (is_rd2 ? sr2 : sr3);

  // The status byte is reloaded every eight clocks so that polling sees fresh state.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !sel_s) begin
      rd_r     <= 1'b0;
      rd_sel_r <= 2'h0;
      out_sh_r <= 8'h00;
      so_r     <= 1'b0;
    end else if (rd_start) begin
      rd_r     <= 1'b1;
      rd_sel_r <= rd_sel;
      out_sh_r <= first_byte;
    end else if (byte_done && rd_r) begin
      out_sh_r <= rd_byte;
    end else if (sclk_fall && rd_r) begin
      so_r     <= out_sh_r[7];
      out_sh_r <= {out_sh_r[6:0], out_sh_r[7]};
    end
  end

  assign so    = so_r;
  assign so_oe = sel_s & rd_r;

  // Instruction decode at the end of a whole-byte frame.
  wire       go        = frame_end & (bit_cnt_r == 3'h0) & (byte_cnt_r != 3'h0);
  wire [2:0] nb        = byte_cnt_r;
  wire       st_idle   = (st_r == fwps_pkg::FWPS_ST_IDLE);
  wire       st_busy   = (st_r == fwps_pkg::FWPS_ST_BUSY);
  wire       st_down   = (st_r == fwps_pkg::FWPS_ST_DOWN);
  wire       op_wren   = (opcode_r == `FWPS_OP_WREN);
  wire       op_wrdi   = (opcode_r == `FWPS_OP_WRDI);
  wire       op_wrsr   = (opcode_r == `FWPS_OP_WRSR);
  wire       op_wrsr3  = (opcode_r == `FWPS_OP_WRSR3);
  wire       op_prog   = (opcode_r == `FWPS_OP_PROG);
  wire       op_se     = (opcode_r == `FWPS_OP_SERASE);
  wire       op_be     = (opcode_r == `FWPS_OP_BERASE);
  wire       op_ce     = (opcode_r == `FWPS_OP_CERASE);
  wire       op_lock   = (opcode_r == `FWPS_OP_LOCK);
  wire       op_unlock = (opcode_r == `FWPS_OP_UNLOCK);

  // Writes need the power-up delay over and an idle, awake device.
  wire wr_ok  = go & st_idle & puw_done_r;
  wire sr_pin = srp_r & ~qe_r & ~wp_n_s;
  wire sr_ok  = wel_r & ~srl_r & ~sr_pin;

  wire x_wren   = wr_ok & op_wren & (nb == `FWPS_NB_ONE);
  wire x_wrdi   = go & st_idle & op_wrdi & (nb == `FWPS_NB_ONE);
  wire x_srwr   = wr_ok & op_wrsr & sr_ok & ((nb == `FWPS_NB_SR1) | (nb == `FWPS_NB_SR12));
  wire x_sr3    = wr_ok & op_wrsr3 & sr_ok & (nb == `FWPS_NB_SR1);
  wire x_addr   = wr_ok & wel_r & (nb == `FWPS_NB_ADDR);
  wire x_pa     = x_addr & (op_prog | op_se | op_be);
  wire x_ce     = wr_ok & wel_r & op_ce & (nb == `FWPS_NB_ONE);
  wire x_lock   = x_addr & op_lock;
  wire x_unlock = x_addr & op_unlock;
  wire x_pd     = go & st_idle & (opcode_r == `FWPS_OP_PDOWN);
  wire x_rel    = go & st_down & (opcode_r == `FWPS_OP_RELEASE);
  wire x_sus    = go & st_busy & (op_r != fwps_pkg::FWPS_OP_SRWR)
                  & (opcode_r == `FWPS_OP_SUSPEND);
  wire x_res    = go & (st_r == fwps_pkg::FWPS_ST_SUSP) & (opcode_r == `FWPS_OP_RESUME);

  // Range decode in 4KB sector units out of the whole array.
  wire [8:0] tgt     = buf_r[`FWPS_ADDR_HI:`FWPS_ADDR_LO];
  wire [2:0] bp_m1   = bp_r - 3'h1;
  wire [2:0] sec_sh  = (bp_m1 > `FWPS_BP_SEC_CAP) ? `FWPS_BP_SEC_CAP : bp_m1;
  wire [9:0] sz_sec  = (bp_r == `FWPS_BP_ALL_SEC) ? `FWPS_SECTORS : (`FWPS_SECT_ONE << sec_sh);
  wire [9:0] sz_blk  = (bp_r >= `FWPS_BP_ALL_BLK) ? `FWPS_SECTORS : (`FWPS_BLK_SECT << bp_m1);
  wire [9:0] bp_size = (bp_r == `FWPS_RST_BP) ? `FWPS_NONE
                       : (sec_r ? sz_sec : sz_blk);
  wire       in_rng  = tb_r ? ({1'b0, tgt} < bp_size)
                       : ({1'b0, tgt} >= (`FWPS_SECTORS - bp_size));
  wire       bp_prot = in_rng ^ cmp_r;

  // Lock index: bottom sectors, top sectors, then the 30 middle blocks.
  wire [4:0] blk      = tgt[8:4];
  wire [3:0] sct      = tgt[3:0];
  wire [4:0] blk_m1   = blk - 5'h01;
  wire [5:0] lock_idx = (blk == `FWPS_BLK_BOT) ? {2'h0, sct}
                        : ((blk == `FWPS_BLK_TOP) ? {2'h1, sct} : {1'b1, blk_m1});
  wire       lk_prot  = lock_r[lock_idx];
  wire       tgt_prot = wps_r ? lk_prot : bp_prot;
  wire       any_prot = wps_r ? (|lock_r)
                        : (cmp_r ? (bp_size != `FWPS_SECTORS) : (bp_size != `FWPS_NONE));

  // Protected targets leave the array untouched.
  wire arr_start = (x_pa & ~tgt_prot) | (x_ce & ~any_prot);
  wire sr_start  = x_srwr | x_sr3;
  wire wel_clr   = x_wrdi | x_pa | x_ce | x_srwr | x_sr3 | x_lock | x_unlock;

  wire fwps_pkg::fwps_op_e arr_op = op_prog ? fwps_pkg::FWPS_OP_PROG
                                  : (op_se ? fwps_pkg::FWPS_OP_SERASE
                                  : (op_be ? fwps_pkg::FWPS_OP_BERASE : fwps_pkg::FWPS_OP_CERASE));

  // Power-up write delay counter.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      puw_cnt_r  <= 12'h000;
      puw_done_r <= 1'b0;
    end else if (!puw_done_r) begin
      puw_cnt_r  <= puw_cnt_r + 12'h001;
      puw_done_r <= (puw_cnt_r == `FWPS_PUW_CYC - 12'h001);
    end
  end

  // Write enable latch.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wel_r <= 1'b0;
    end else if (x_wren) begin
      wel_r <= 1'b1;
    end else if (wel_clr) begin
      wel_r <= 1'b0;
    end
  end

  // Status register writes take effect when accepted.
  wire       two_byte = (nb == `FWPS_NB_SR12);
  wire [7:0] wr_sr1   = two_byte ? buf_r[15:8] : buf_r[7:0];
  wire [7:0] wr_sr2   = buf_r[7:0];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bp_r  <= `FWPS_RST_BP;
      tb_r  <= 1'b0;
      sec_r <= 1'b0;
      srp_r <= 1'b0;
      srl_r <= 1'b0;
      qe_r  <= 1'b0;
      cmp_r <= 1'b0;
      wps_r <= 1'b0;
    end else begin
      if (x_srwr) begin
        bp_r  <= wr_sr1[`FWPS_S_BP_HI:`FWPS_S_BP_LO];
        tb_r  <= wr_sr1[`FWPS_S_TB];
        sec_r <= wr_sr1[`FWPS_S_SEC];
        srp_r <= wr_sr1[`FWPS_S_SRP];
      end
      if (x_srwr && two_byte) begin
        srl_r <= wr_sr2[`FWPS_S2_SRL];
        qe_r  <= wr_sr2[`FWPS_S2_QE];
        cmp_r <= wr_sr2[`FWPS_S2_CMP];
      end
      if (x_sr3) begin
        wps_r <= buf_r[`FWPS_S3_WPS];
      end
    end
  end

  // Individual locks, all set at power-on.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lock_r <= `FWPS_RST_LOCKS;
    end else if (x_lock) begin
      lock_r[lock_idx] <= 1'b1;
    end else if (x_unlock) begin
      lock_r[lock_idx] <= 1'b0;
    end
  end

  // Operation sequencing.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      fwps_pkg::FWPS_ST_IDLE: begin
        if (arr_start || sr_start) begin
          st_nxt = fwps_pkg::FWPS_ST_BUSY;
        end else if (x_pd) begin
          st_nxt = fwps_pkg::FWPS_ST_DOWN;
        end
      end
      fwps_pkg::FWPS_ST_BUSY: begin
        if (x_sus) begin
          st_nxt = fwps_pkg::FWPS_ST_SUSP;
        end else if (run_cnt_r == 12'h001) begin
          st_nxt = fwps_pkg::FWPS_ST_IDLE;
        end
      end
      fwps_pkg::FWPS_ST_SUSP: begin
        if (x_res) begin
          st_nxt = fwps_pkg::FWPS_ST_BUSY;
        end
      end
      fwps_pkg::FWPS_ST_DOWN: begin
        if (x_rel) begin
          st_nxt = fwps_pkg::FWPS_ST_IDLE;
        end
      end
      default: begin
        st_nxt = fwps_pkg::FWPS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= fwps_pkg::FWPS_ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Run timer holds its count while suspended.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      run_cnt_r <= 12'h000;
      op_r      <= fwps_pkg::FWPS_OP_NONE;
      go_r      <= 1'b0;
      addr_r    <= 24'h000000;
    end else begin
      go_r <= arr_start;
      if (arr_start) begin
        run_cnt_r <= `FWPS_TPROG_CYC;
        op_r      <= arr_op;
        addr_r    <= buf_r;
      end else if (sr_start) begin
        run_cnt_r <= `FWPS_TW_CYC;
        op_r      <= fwps_pkg::FWPS_OP_SRWR;
      end else if (st_busy && !x_sus && run_cnt_r != 12'h000) begin
        run_cnt_r <= run_cnt_r - 12'h001;
        if (run_cnt_r == 12'h001) begin
          op_r <= fwps_pkg::FWPS_OP_NONE;
        end
      end
    end
  end

  assign array_go   = go_r;
  assign array_op   = op_r;
  assign array_addr = addr_r;
  assign busy       = busy_bit;

endmodule

// [hdl/fwps_regs.svh]
// Constants for the flash write-protect and status block.
// How it works
// - Power-on reset blocks every instruction.
// - Write-type instructions refused until power-up delay.
// - Latch clear at power-up; writes need latch.
// - Power-down accepts only release instruction.
// - Lock bits: 30 blocks, 32 edge sectors.
// - Locked region ignores program and erase.
// - Locks set at power-on; 39h unlocks.
// - Scheme select picks range bits or locks.
// - Status writes gated by guard, lock, latch, pin.
// - Busy bit high while operation runs.
// - Busy accepts only status read, and suspend unless writing status.
// - Busy clears when operation completes.
// - Write enable sets the read-only latch.
// - Latch clears after disable, program, erase, writes.
// - Three protect bits size the guarded range.
// - Protect bits reset to zero, nothing guarded.
// - Top/bottom bit anchors range, default top.
// - Granule bit picks sectors or blocks.
// - Invert bit swaps protected and writable regions.
// - Guard bit with low pin locks status.
// - Lockdown bit blocks status writes until power cycle.
// - Quad enable disables pin gating.
`ifndef FWPS_REGS_SVH
`define FWPS_REGS_SVH

// Instruction codes.
`define FWPS_OP_WREN     8'h06
`define FWPS_OP_WRDI     8'h04
`define FWPS_OP_RDSR1    8'h05
`define FWPS_OP_RDSR2    8'h35
`define FWPS_OP_RDSR3    8'h15
`define FWPS_OP_WRSR     8'h01
`define FWPS_OP_WRSR3    8'h11
`define FWPS_OP_PROG     8'h02
`define FWPS_OP_SERASE   8'h20
`define FWPS_OP_BERASE   8'hD8
`define FWPS_OP_CERASE   8'hC7
`define FWPS_OP_LOCK     8'h36
`define FWPS_OP_UNLOCK   8'h39
`define FWPS_OP_PDOWN    8'hB9
`define FWPS_OP_RELEASE  8'hAB
`define FWPS_OP_SUSPEND  8'h75
`define FWPS_OP_RESUME   8'h7A

// Frame byte counts.
`define FWPS_NB_ONE      3'h1
`define FWPS_NB_SR1      3'h2
`define FWPS_NB_SR12     3'h3
`define FWPS_NB_ADDR     3'h4
`define FWPS_NB_MAX      3'h4
`define FWPS_BIT_LAST    3'h7

// Status register 1 fields.
`define FWPS_S_BUSY      0
`define FWPS_S_WEL       1
`define FWPS_S_BP_LO     2
`define FWPS_S_BP_HI     4
`define FWPS_S_TB        5
`define FWPS_S_SEC       6
`define FWPS_S_SRP       7
// Status register 2 fields, bit position within the byte.
`define FWPS_S2_SRL      0
`define FWPS_S2_QE       1
`define FWPS_S2_CMP      6
`define FWPS_S2_SUS      7
// Status register 3 fields, bit position within the byte.
`define FWPS_S3_WPS      2

// Reset values.
`define FWPS_RST_BP      3'h0
`define FWPS_RST_LOCKS   {62{1'b1}}
`define FWPS_LOCKS       62

// Array geometry in 4KB sector units.
`define FWPS_SECTORS     10'h200
`define FWPS_NONE        10'h000
`define FWPS_BLK_SECT    10'h010
`define FWPS_SECT_ONE    10'h001
`define FWPS_BLK_TOP     5'h1F
`define FWPS_BLK_BOT     5'h00
`define FWPS_BP_ALL_BLK  3'h6
`define FWPS_BP_ALL_SEC  3'h7
`define FWPS_BP_SEC_CAP  3'h3
`define FWPS_ADDR_HI     20
`define FWPS_ADDR_LO     12

// Timing.
`define FWPS_CLK_MHZ     10
`define FWPS_PUW_US      10
`define FWPS_TW_US       20
`define FWPS_TPROG_US    100
`define FWPS_PUW_CYC     12'(`FWPS_PUW_US * `FWPS_CLK_MHZ)
`define FWPS_TW_CYC      12'(`FWPS_TW_US * `FWPS_CLK_MHZ)
`define FWPS_TPROG_CYC   12'(`FWPS_TPROG_US * `FWPS_CLK_MHZ)

`endif

// [hdl/fwps_pkg.sv]
// Types shared by the flash write-protect and status block.
package fwps_pkg;

  typedef enum logic [2:0] {
    FWPS_OP_NONE   = 3'h0,
    FWPS_OP_PROG   = 3'h1,
    FWPS_OP_SERASE = 3'h2,
    FWPS_OP_BERASE = 3'h3,
    FWPS_OP_CERASE = 3'h4,
    FWPS_OP_SRWR   = 3'h5
  } fwps_op_e;

  typedef enum logic [1:0] {
    FWPS_ST_IDLE = 2'h0,
    FWPS_ST_BUSY = 2'h1,
    FWPS_ST_SUSP = 2'h2,
    FWPS_ST_DOWN = 2'h3
  } fwps_state_e;

endpackage

// [hdl/fwps_sync.sv]
// Two-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module fwps_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

// [verif/fwps_top_sva.sv]
// Concurrent checks on the ports of the flash write-protect and status block.
`timescale 1ns/1ps
module fwps_top_sva (
  // Clock and power-on reset
  input wire logic         ref_clk,
  input wire logic         rst_n,
  // Serial link pins
  input wire logic         sclk,
  input wire logic         cs_n,
  input wire logic         si,
  input wire logic         wp_n,
  input wire logic         so,
  input wire logic         so_oe,
  // Array engine
  input wire logic         array_go,
  input fwps_pkg::fwps_op_e array_op,
  input wire logic [23:0]  array_addr,
  input wire logic         busy
);
  logic [7:0]  up_cnt;
  logic [10:0] busy_cnt;

  // Cycles since power-on reset released, and length of the current busy spell.
  always_ff @(posedge ref_clk) begin
    up_cnt <= !rst_n ? 8'h00 : (up_cnt < 8'hC8 ? up_cnt + 8'h01 : up_cnt);
    busy_cnt <= (!rst_n || !busy) ? 11'h000 : busy_cnt + 11'h001;
  end

  reset_quiet_a: assert property (@(posedge ref_clk) !rst_n |=> !busy && !array_go && !so_oe)
    else $error("outputs active during power-on reset");
  power_up_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    up_cnt < 8'h64 |-> !array_go && !busy) else $error("array work inside power-up delay");
  go_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    array_go |-> busy && array_op != fwps_pkg::FWPS_OP_NONE) else $error("start without busy");
  go_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n) array_go |=> !array_go)
    else $error("start pulse longer than one cycle");
  busy_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n) array_go |-> !$past(busy))
    else $error("operation started while busy");
  busy_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n) busy_cnt <= 11'h3E8)
    else $error("busy held too long");
  addr_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) $changed(array_addr) |-> array_go)
    else $error("target address moved without a start");
  go_closed_a: assert property (@(posedge ref_clk) disable iff (!rst_n) array_go |-> cs_n && $past(cs_n))
    else $error("start inside an open frame");
endmodule

bind fwps_top fwps_top_sva chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so),
  .so_oe(so_oe), .array_go(array_go), .array_op(array_op), .array_addr(array_addr), .busy(busy)
);

// [verif/fwps_host.sv]
// Behavioural host controller that frames instructions on the serial link.
`timescale 1ns/1ps
module fwps_host (
  // System clock that paces the link
  input  wire logic ref_clk,
  // Serial link pins
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end

  // Mode 0, one bit per 800 ns; the clock rests low between frames and the data line toggles
  // whenever it carries nothing, so no stale bit can pass for a real one.
  task automatic xfer(input logic [31:0] tx, input int nbits, input bit rd, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    @(negedge ref_clk);
    cs_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (i = 0; i < nbits + (rd ? 8 : 0); i++) begin
      si = (i < nbits) ? tx[31-i] : ~si;
      repeat (4) @(negedge ref_clk);
      sclk = 1'b1;
      repeat (4) @(negedge ref_clk);
      if (i >= nbits) rx = {rx[6:0], so};
      sclk = 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule

// [verif/fwps_tb.sv]
// Self-checking bench for the flash write-protect and status block.
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] s1; logic [7:0] s2; logic [23:0] a; int g;} fwps_row_s;
  logic               ref_clk;
  logic               rst_n;
  logic               sclk;
  logic               cs_n;
  logic               si;
  logic               wp_n;
  logic               so;
  logic               so_oe;
  logic               array_go;
  fwps_pkg::fwps_op_e array_op;
  logic [23:0]        array_addr;
  logic               busy;
  logic [7:0]         rx;
  int                 num_errors = 0;
  int                 total_checks = 0;
  int                 gos = 0;
  int                 cyc = 0;
  int                 g0;
  fwps_row_s          rows [11] = '{'{8'h00, 8'h00, 24'h1FF000, 1}, '{8'h04, 8'h00, 24'h1F0000, 0},
    '{8'h04, 8'h00, 24'h1EF000, 1}, '{8'h24, 8'h00, 24'h00F000, 0}, '{8'h24, 8'h00, 24'h1F0000, 1},
    '{8'h44, 8'h00, 24'h1FF000, 0}, '{8'h44, 8'h00, 24'h1FE000, 1}, '{8'h04, 8'h40, 24'h1F0000, 1},
    '{8'h04, 8'h40, 24'h000000, 0}, '{8'h18, 8'h00, 24'h000000, 0}, '{8'h00, 8'h00, 24'h000000, 1}};

  fwps_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so),
    .so_oe(so_oe), .array_go(array_go), .array_op(array_op), .array_addr(array_addr), .busy(busy));
  fwps_host host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Counts start pulses and cuts a hang short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (array_go === 1'b1) gos <= gos + 1;
    if (cyc == 80000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmd(input logic [31:0] tx, input int n);
    host.xfer(tx, n, 1'b0, rx);
  endtask

  task automatic sr(input logic [7:0] op, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    host.xfer({op, 24'h000000}, 8, 1'b1, rx);
    chk("status", {16'h0000, e & m}, {16'h0000, rx & m});
  endtask

  task automatic idle();
    int i;
    for (i = 0; i < 1200 && busy !== 1'b0; i++) @(negedge ref_clk);
    chk("busy", 24'h000000, {23'h000000, busy});
  endtask

  // Optional write enable, then a sector erase whose start pulse count is compared.
  task automatic ers(input logic [23:0] a, input int g, input bit w);
    if (w) cmd({8'h06, 24'h000000}, 8);
    g0 = gos;
    cmd({8'h20, a}, 32);
    chk("starts", 24'(g), 24'(gos - g0));
    idle();
  endtask

  task automatic wsr(input logic [31:0] tx, input int n);
    cmd({8'h06, 24'h000000}, 8);
    cmd(tx, n);
    idle();
  endtask

  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    cmd({8'h06, 24'h000000}, 8);
    sr(8'h05, 8'h00);
    sr(8'h35, 8'h00);
    sr(8'h15, 8'h00);
    $display("reset test done");
    cmd({8'h06, 24'h000000}, 7);
    sr(8'h05, 8'h00);
    cmd({8'h06, 24'h000000}, 8);
    sr(8'h05, 8'h02);
    cmd({8'h04, 24'h000000}, 8);
    sr(8'h05, 8'h00);
    ers(24'h000000, 0, 1'b0);
    cmd({8'hB9, 24'h000000}, 8);
    cmd({8'h06, 24'h000000}, 8);
    chk("so_oe", 24'h000000, {23'h000000, so_oe});
    cmd({8'hAB, 24'h000000}, 8);
    sr(8'h05, 8'h00);
    $display("latch test done");
    foreach (rows[i]) begin
      wsr({8'h01, rows[i].s1, rows[i].s2, 8'h00}, 24);
      sr(8'h05, rows[i].s1);
      ers(rows[i].a, rows[i].g, 1'b1);
      $display("protection row %0d done", i);
    end
    cmd({8'h06, 24'h000000}, 8);
    g0 = gos;
    cmd({8'h20, 24'h00A000}, 32);
    chk("starts", 24'h000001, 24'(gos - g0));
    chk("op", 24'(fwps_pkg::FWPS_OP_SERASE), 24'(array_op));
    chk("addr", 24'h00A000, array_addr);
    sr(8'h05, 8'h01);
    cmd({8'h06, 24'h000000}, 8);
    sr(8'h05, 8'h01);
    idle();
    sr(8'h05, 8'h00);
    cmd({8'h06, 24'h000000}, 8);
    cmd({8'hD8, 24'h020000}, 32);
    chk("op", 24'(fwps_pkg::FWPS_OP_BERASE), 24'(array_op));
    cmd({8'h75, 24'h000000}, 8);
    sr(8'h35, 8'h80);
    sr(8'h05, 8'h00);
    cmd({8'h7A, 24'h000000}, 8);
    sr(8'h05, 8'h01);
    idle();
    cmd({8'h06, 24'h000000}, 8);
    g0 = gos;
    cmd({8'hC7, 24'h000000}, 8);
    chk("starts", 24'h000001, 24'(gos - g0));
    chk("op", 24'(fwps_pkg::FWPS_OP_CERASE), 24'(array_op));
    idle();
    $display("busy test done");
    wsr({8'h11, 8'h04, 16'h0000}, 16);
    sr(8'h15, 8'h04);
    ers(24'h010000, 0, 1'b1);
    wsr({8'h39, 24'h010000}, 32);
    ers(24'h010000, 1, 1'b1);
    wsr({8'h39, 24'h1FF000}, 32);
    ers(24'h1FE000, 0, 1'b1);
    ers(24'h1FF000, 1, 1'b1);
    wsr({8'h36, 24'h010000}, 32);
    ers(24'h010000, 0, 1'b1);
    wsr({8'h11, 24'h000000}, 16);
    $display("lock test done");
    wp_n = 1'b0;
    wsr({8'h01, 8'h80, 16'h0000}, 24);
    wsr({8'h01, 8'h84, 16'h0000}, 24);
    sr(8'h05, 8'h80, 8'hFD);
    wp_n = 1'b1;
    wsr({8'h01, 8'h84, 8'h02, 8'h00}, 24);
    sr(8'h05, 8'h84, 8'hFD);
    wp_n = 1'b0;
    wsr({8'h01, 8'h88, 8'h03, 8'h00}, 24);
    sr(8'h05, 8'h88, 8'hFD);
    wsr({8'h01, 8'h00, 8'h02, 8'h00}, 24);
    sr(8'h05, 8'h88, 8'hFD);
    sr(8'h35, 8'h03);
    $display("guard test done");
    rst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    sr(8'h35, 8'h00);
    sr(8'h05, 8'h00);
    $display("second reset test done");
    conclude();
  end
endmodule
